// [rtl/hpp_pkg.sv]
// holds constants and types shared by the host port and its decoder
// assumes a single 25 MHz clock domain
package hpp_pkg;

    // =========================================================
    // host address map (word addresses, 7 bits)
    localparam int unsigned HPP_ADDR_W = 7;
    localparam logic [2:0] HPP_RX_FIFO_PAGE = 3'h0;
    localparam logic [2:0] HPP_TX_FIFO_PAGE = 3'h1;
    localparam int unsigned HPP_PAGE_MSB = 6;
    localparam int unsigned HPP_PAGE_LSB = 4;
    localparam int unsigned HPP_FIFO_KEEP_W = 2;

    // =========================================================
    // reset values
    localparam logic HPP_RST_SPEED = 1'h1;
    localparam logic HPP_RST_BUS32 = 1'h0;
    localparam logic [31:0] HPP_RST_DATA = 32'h0000_0000;

    // =========================================================
    // types
    typedef enum logic [1:0] {
        HPP_TGT_CSR,
        HPP_TGT_RX_FIFO,
        HPP_TGT_TX_FIFO
    } hpp_target_t;

    typedef enum logic [1:0] {
        HPP_PIN_EEPROM,
        HPP_PIN_GPO,
        HPP_PIN_MON_TXEN,
        HPP_PIN_MON_TXCLK
    } hpp_pin_mode_t;

    typedef enum logic {
        HPP_ST_STRAP,
        HPP_ST_RUN
    } hpp_state_t;

endpackage : hpp_pkg

// [rtl/hpp_acc_if.sv]
// carries host strobes into the access decoder and its pulses back
// assumes host pins already synchronous to sys_clk_i
`timescale 1ns/100ps
`default_nettype none
interface hpp_acc_if;
    import hpp_pkg::*;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic fifo_sel;
    logic low_power;
    logic [HPP_ADDR_W-1:0] addr;
    logic rd_start;
    logic wr_start;
    logic wr_take;
    logic wake;
    hpp_target_t target;
    logic [HPP_ADDR_W-1:0] word_addr;

    modport dec (
        input cs_n, rd_n, wr_n, fifo_sel, low_power, addr,
        output rd_start, wr_start, wr_take, wake, target, word_addr
    );
    modport top (
        output cs_n, rd_n, wr_n, fifo_sel, low_power, addr,
        input rd_start, wr_start, wr_take, wake, target, word_addr
    );
endinterface : hpp_acc_if
`default_nettype wire

// [rtl/hpp_decode.sv]
// access decoder: strobe edges, target decode, wake and write gating
// assumes synchronous strobes and a synchronised active-low reset
`timescale 1ns/100ps
`default_nettype none
module hpp_decode
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // access carrier
    hpp_acc_if.dec acc
);

    typedef struct packed {
        logic rd_act;
        logic wr_act;
        logic read_seen;
    } hpp_dec_st_t;

    hpp_dec_st_t st_ff;
    hpp_dec_st_t nxt_st;
    logic rd_lvl;
    logic wr_lvl;

    // =========================================================
    // qualification
    assign rd_lvl = !acc.cs_n && !acc.rd_n;
    assign wr_lvl = !acc.cs_n && !acc.wr_n;
    assign acc.rd_start = rd_lvl && !st_ff.rd_act;
    assign acc.wr_start = wr_lvl && !st_ff.wr_act;
    assign acc.wake = acc.wr_start && acc.low_power;
    // writes before the first read are dropped, as the part expects
    assign acc.wr_take = acc.wr_start && st_ff.read_seen
        && !acc.low_power;

    // =========================================================
    // target decode
    always_comb
    begin
        acc.word_addr = acc.addr;
        if (acc.fifo_sel)
        begin
            // upper address ignored in fifo mode
            acc.word_addr = {{(HPP_ADDR_W-HPP_FIFO_KEEP_W){1'b0}},
                acc.addr[HPP_FIFO_KEEP_W-1:0]};
            acc.target = acc.wr_n ? HPP_TGT_RX_FIFO : HPP_TGT_TX_FIFO;
        end
        else if (acc.addr[HPP_PAGE_MSB:HPP_PAGE_LSB] == HPP_RX_FIFO_PAGE)
        begin
            acc.target = HPP_TGT_RX_FIFO;
        end
        else if (acc.addr[HPP_PAGE_MSB:HPP_PAGE_LSB] == HPP_TX_FIFO_PAGE)
        begin
            acc.target = HPP_TGT_TX_FIFO;
        end
        else
        begin
            acc.target = HPP_TGT_CSR;
        end
    end

    // =========================================================
    // state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rd_act = rd_lvl;
        nxt_st.wr_act = wr_lvl;
        if (acc.wake)
        begin
            nxt_st.read_seen = 1'b0;
        end
        else if (acc.rd_start)
        begin
            nxt_st.read_seen = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule : hpp_decode
`default_nettype wire

// [rtl/hpp_host_port.sv]
// host port pins, power-up straps, irq pin, crossover and eeprom pin mux
// assumes host pins synchronous to sys_clk_i; core logic lies outside
`timescale 1ns/100ps
`default_nettype none
module hpp_host_port
    import hpp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // host bus
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic [HPP_ADDR_W-1:0] addr_i,
    input wire logic fifo_sel_i,
    input wire logic [31:0] data_i,
    output logic [31:0] data_o,
    output logic [31:0] data_oe_o,
    output logic [15:0] data_hi_pd_en_o,
    // core access side
    input wire logic big_endian_i,
    input wire logic low_power_i,
    input wire logic [31:0] core_rdata_i,
    output logic core_rd_o,
    output logic core_wr_o,
    output hpp_target_t core_target_o,
    output logic [HPP_ADDR_W-1:0] core_addr_o,
    output logic [31:0] core_wdata_o,
    output logic wake_o,
    // straps and defaults
    input wire logic speed_strap_i,
    output logic bus32_o,
    output logic link_100_o,
    output logic full_duplex_o,
    output logic autoneg_en_o,
    // interrupt pin
    input wire logic [3:0] irq_sources_i,
    input wire logic [1:0] irq_src_sel_i,
    input wire logic irq_pol_high_i,
    input wire logic irq_open_drain_i,
    output logic irq_o,
    output logic irq_oe_o,
    // crossover
    input wire logic crossover_auto_enable_i,
    input wire logic reversal_detected_i,
    input wire logic manual_reverse_i,
    output logic crossover_auto_o,
    output logic swap_pairs_o,
    // eeprom data pin mux
    input wire hpp_pin_mode_t pin_mode_i,
    input wire logic general_output_three_i,
    input wire logic mii_tx_en_i,
    input wire logic mii_tx_clk_i,
    input wire logic ee_select_i,
    input wire logic ee_dout_i,
    input wire logic ee_dout_en_i,
    input wire logic eeprom_data_io_i,
    output logic eeprom_data_io_o,
    output logic eeprom_data_io_oe_o,
    output logic eeprom_select_o,
    output logic ee_din_o
);

    typedef struct packed {
        hpp_state_t state;
        logic speed;
        logic bus32;
        logic [31:0] rdata;
        logic [31:0] wdata;
        logic rd;
        logic wr;
        logic wake;
        hpp_target_t target;
        logic [HPP_ADDR_W-1:0] addr;
        logic irq;
        logic irq_oe;
        logic swap;
    } hpp_st_t;

    hpp_st_t st_ff;
    hpp_st_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic irq_active;
    logic [31:0] rd_ord;
    logic [31:0] wr_ord;

    hpp_acc_if acc ();

    // =========================================================
    // reset release
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // =========================================================
    // access decoder
    assign acc.cs_n = chip_select_n_i;
    assign acc.rd_n = read_strobe_n_i;
    assign acc.wr_n = write_strobe_n_i;
    assign acc.fifo_sel = fifo_sel_i;
    assign acc.low_power = low_power_i;
    assign acc.addr = addr_i;

    hpp_decode u_decode (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .acc(acc)
    );

    // =========================================================
    // byte order; a 16-bit bus swaps within the low half only
    function automatic logic [31:0] hpp_order(
        input logic [31:0] d,
        input logic be,
        input logic w32
    );
        logic [31:0] r;
        r = d;
        if (be && w32)
        begin
            r = {d[7:0], d[15:8], d[23:16], d[31:24]};
        end
        else if (be)
        begin
            r = {d[31:16], d[7:0], d[15:8]};
        end
        return r;
    endfunction : hpp_order

    assign rd_ord = hpp_order(core_rdata_i, big_endian_i, st_ff.bus32);
    assign wr_ord = hpp_order(data_i, big_endian_i, st_ff.bus32);

    assign irq_active = irq_sources_i[irq_src_sel_i];

    // =========================================================
    // next state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rd = acc.rd_start;
        nxt_st.wr = acc.wr_take;
        nxt_st.wake = acc.wake;
        // straps caught once, first cycle after release, then frozen
        if (st_ff.state == HPP_ST_STRAP)
        begin
            nxt_st.speed = speed_strap_i;
            nxt_st.bus32 = eeprom_data_io_i;
            nxt_st.state = HPP_ST_RUN;
        end
        if (acc.rd_start || acc.wr_start)
        begin
            nxt_st.target = acc.target;
            nxt_st.addr = acc.word_addr;
        end
        if (acc.rd_start)
        begin
            nxt_st.rdata = rd_ord;
        end
        if (acc.wr_take)
        begin
            nxt_st.wdata = st_ff.bus32 ? wr_ord : {16'h0000, wr_ord[15:0]};
        end
        if (irq_open_drain_i)
        begin
            nxt_st.irq = 1'b0;
            nxt_st.irq_oe = irq_active;
        end
        else
        begin
            nxt_st.irq = irq_active ~^ irq_pol_high_i ? 1'b1 : 1'b0;
            nxt_st.irq_oe = 1'b1;
        end
        // auto detection only counts when enabled; manual always wins
        nxt_st.swap = manual_reverse_i
            || (crossover_auto_enable_i && reversal_detected_i);
    end

    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '{state: HPP_ST_STRAP, speed: HPP_RST_SPEED,
                bus32: HPP_RST_BUS32, rdata: HPP_RST_DATA,
                wdata: HPP_RST_DATA, target: HPP_TGT_CSR, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // =========================================================
    // host pins
    always_comb
    begin
        data_oe_o = '0;
        if (!chip_select_n_i && !read_strobe_n_i)
        begin
            data_oe_o = st_ff.bus32 ? 32'hffff_ffff : 32'h0000_ffff;
        end
    end
    assign data_o = st_ff.rdata;
    assign data_hi_pd_en_o = {16{!st_ff.bus32}};

    assign core_rd_o = st_ff.rd;
    assign core_wr_o = st_ff.wr;
    assign core_target_o = st_ff.target;
    assign core_addr_o = st_ff.addr;
    assign core_wdata_o = st_ff.wdata;
    assign wake_o = st_ff.wake;

    // =========================================================
    // defaults, irq, crossover
    assign bus32_o = st_ff.bus32;
    assign link_100_o = st_ff.speed;
    assign autoneg_en_o = st_ff.speed;
    assign full_duplex_o = 1'b0;
    assign irq_o = st_ff.irq;
    assign irq_oe_o = st_ff.irq_oe;
    assign crossover_auto_o = crossover_auto_enable_i;
    assign swap_pairs_o = st_ff.swap;

    // =========================================================
    // eeprom data pin mux; the clock monitor stays combinational
    always_comb
    begin
        eeprom_select_o = 1'b0;
        ee_din_o = 1'b0;
        eeprom_data_io_oe_o = 1'b1;
        eeprom_data_io_o = 1'b0;
        unique case (pin_mode_i)
            HPP_PIN_EEPROM:
            begin
                eeprom_select_o = ee_select_i;
                ee_din_o = eeprom_data_io_i;
                eeprom_data_io_o = ee_dout_i;
                eeprom_data_io_oe_o = ee_dout_en_i;
            end
            HPP_PIN_GPO: eeprom_data_io_o = general_output_three_i;
            HPP_PIN_MON_TXEN: eeprom_data_io_o = mii_tx_en_i;
            HPP_PIN_MON_TXCLK: eeprom_data_io_o = mii_tx_clk_i;
        endcase
    end

endmodule : hpp_host_port
`default_nettype wire

// [tb/hpp_host_port_props.sv]
// checker on the host port top ports
// assumes one clock domain; bound to every hpp_host_port
`timescale 1ns/100ps
`default_nettype none
module hpp_host_port_props
    import hpp_pkg::*;
(
    // clock, reset, inputs
    input wire logic sys_clk_i, nrst_i, chip_select_n_i,
    input wire logic read_strobe_n_i, write_strobe_n_i, low_power_i,
    input wire logic crossover_auto_enable_i, reversal_detected_i,
    input wire logic manual_reverse_i,
    input wire hpp_pin_mode_t pin_mode_i,
    // outputs
    input wire logic core_rd_o, core_wr_o, wake_o, bus32_o, link_100_o,
    input wire logic autoneg_en_o, full_duplex_o, crossover_auto_o,
    input wire logic swap_pairs_o, eeprom_select_o, ee_din_o,
    input wire logic [31:0] data_oe_o,
    input wire logic [15:0] data_hi_pd_en_o
);
    // ========================================
    // cycles since release, saturating
    logic [2:0] cnt_ff;
    always_ff @(posedge sys_clk_i or negedge nrst_i)
        if (!nrst_i)
            cnt_ff <= 3'h0;
        else if (cnt_ff != 3'h7)
            cnt_ff <= cnt_ff + 3'h1;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // ========================================
    // properties
    property p_rd;
        !chip_select_n_i && !read_strobe_n_i
        && $past(chip_select_n_i || read_strobe_n_i) |=> core_rd_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read missed");
    property p_cs;
        chip_select_n_i |=> !core_rd_o && !core_wr_o;
    endproperty
    a_cs: assert property (p_cs) else $error("unselected");
    property p_oe;
        data_oe_o == ((!chip_select_n_i && !read_strobe_n_i) ?
            {{16{bus32_o}}, 16'hffff} : 32'h0);
    endproperty
    a_oe: assert property (p_oe) else $error("data oe");
    property p_pd;
        data_hi_pd_en_o == {16{!bus32_o}};
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down");
    // strap latch settles well before count saturates
    property p_hold;
        cnt_ff == 3'h7 |-> $stable(bus32_o) && $stable(link_100_o);
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved");
    property p_spd;
        autoneg_en_o == link_100_o && !full_duplex_o;
    endproperty
    a_spd: assert property (p_spd) else $error("defaults");
    property p_xo;
        crossover_auto_o == crossover_auto_enable_i;
    endproperty
    a_xo: assert property (p_xo) else $error("crossover");
    property p_swap;
        // core flops leave reset two edges after the pin rises
        cnt_ff >= 3'h2 |=> swap_pairs_o == $past(manual_reverse_i
            || (crossover_auto_enable_i && reversal_detected_i));
    endproperty
    a_swap: assert property (p_swap) else $error("swap");
    property p_ees;
        pin_mode_i != HPP_PIN_EEPROM |-> !eeprom_select_o && !ee_din_o;
    endproperty
    a_ees: assert property (p_ees) else $error("ee select");
    property p_wake;
        low_power_i && !chip_select_n_i && !write_strobe_n_i
        && $past(chip_select_n_i || write_strobe_n_i)
        |=> wake_o && !core_wr_o;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    c_rd: cover property (core_rd_o);
    c_wr: cover property (core_wr_o);
    c_wake: cover property (wake_o);
endmodule : hpp_host_port_props
bind hpp_host_port hpp_host_port_props u_props (.sys_clk_i, .nrst_i,
    .chip_select_n_i, .read_strobe_n_i, .write_strobe_n_i, .low_power_i,
    .crossover_auto_enable_i, .reversal_detected_i, .manual_reverse_i,
    .pin_mode_i, .core_rd_o, .core_wr_o, .wake_o, .bus32_o, .link_100_o,
    .autoneg_en_o, .full_duplex_o, .crossover_auto_o, .swap_pairs_o,
    .eeprom_select_o, .ee_din_o, .data_oe_o, .data_hi_pd_en_o);
`default_nettype wire

// [tb/hpp_host_mdl.sv]
// host processor model driving the sram-like strobes
// assumes callers enter acc and rel at falling edges
`timescale 1ns/100ps
`default_nettype none
module hpp_host_mdl
(
    // clock
    input wire logic clk_i,
    // host bus drive
    output logic cs_n_o, rd_n_o, wr_n_o, fifo_o,
    output logic [6:0] addr_o,
    output logic [31:0] data_o
);
    initial
    begin
        {cs_n_o, rd_n_o, wr_n_o, fifo_o} = 4'he;
        addr_o = 7'h0;
        data_o = 32'h0;
    end
    // ========================================
    // strobe held over one rising edge
    task acc(input logic w, c, input logic [6:0] a, input logic f,
        input logic [31:0] d);
        @(negedge clk_i);
        addr_o = a;
        fifo_o = f;
        data_o = d;
        cs_n_o = !c;
        rd_n_o = w;
        wr_n_o = !w;
        @(negedge clk_i);
    endtask : acc
    // released data must not look like held data
    task rel;
        {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
        data_o = ~data_o;
        @(negedge clk_i);
    endtask : rel
endmodule : hpp_host_mdl
`default_nettype wire

// [tb/hpp_host_port_tb_top.sv]
// self-checking bench for the host port
// assumes the host model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module hpp_host_port_tb_top;
    import hpp_pkg::*;
    logic sys_clk_i = 1'h0, nrst_i = 1'h0;
    logic chip_select_n_i, read_strobe_n_i, write_strobe_n_i, fifo_sel_i;
    logic [6:0] addr_i, core_addr_o;
    logic [31:0] data_i, core_rdata_i, data_o, data_oe_o, core_wdata_o;
    logic [31:0] msk;
    logic [15:0] data_hi_pd_en_o;
    logic big_endian_i, low_power_i, core_rd_o, core_wr_o, wake_o;
    hpp_target_t core_target_o;
    logic speed_strap_i, bus32_o, link_100_o, full_duplex_o, autoneg_en_o;
    logic [3:0] irq_sources_i, ov;
    logic [1:0] irq_src_sel_i;
    logic irq_pol_high_i, irq_open_drain_i, irq_o, irq_oe_o, w32, ex;
    logic crossover_auto_enable_i, reversal_detected_i, manual_reverse_i;
    logic crossover_auto_o, swap_pairs_o, general_output_three_i;
    hpp_pin_mode_t pin_mode_i;
    logic mii_tx_en_i, mii_tx_clk_i, ee_select_i, ee_dout_i, ee_dout_en_i;
    logic eeprom_data_io_i, eeprom_data_io_o, eeprom_data_io_oe_o;
    logic eeprom_select_o, ee_din_o;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    hpp_host_mdl mdl (.clk_i(sys_clk_i), .cs_n_o(chip_select_n_i),
        .rd_n_o(read_strobe_n_i), .wr_n_o(write_strobe_n_i),
        .fifo_o(fifo_sel_i), .addr_o(addr_i), .data_o(data_i));
    hpp_host_port DUT (.sys_clk_i, .nrst_i, .chip_select_n_i,
        .read_strobe_n_i, .write_strobe_n_i, .addr_i, .fifo_sel_i, .data_i,
        .data_o, .data_oe_o, .data_hi_pd_en_o, .big_endian_i, .low_power_i,
        .core_rdata_i, .core_rd_o, .core_wr_o, .core_target_o, .core_addr_o,
        .core_wdata_o, .wake_o, .speed_strap_i, .bus32_o, .link_100_o,
        .full_duplex_o, .autoneg_en_o, .irq_sources_i, .irq_src_sel_i,
        .irq_pol_high_i, .irq_open_drain_i, .irq_o, .irq_oe_o,
        .crossover_auto_enable_i, .reversal_detected_i, .manual_reverse_i,
        .crossover_auto_o, .swap_pairs_o, .pin_mode_i,
        .general_output_three_i, .mii_tx_en_i, .mii_tx_clk_i, .ee_select_i,
        .ee_dout_i, .ee_dout_en_i, .eeprom_data_io_i, .eeprom_data_io_o,
        .eeprom_data_io_oe_o, .eeprom_select_o, .ee_din_o);
    // ========================================
    // tasks
    task chk(input logic [31:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task close_out;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task rst(input logic sp, w);
        nrst_i = 1'h0;
        speed_strap_i = sp;
        eeprom_data_io_i = w;
        w32 = w;
        msk = {{16{w}}, 16'hffff};
        repeat (12) @(negedge sys_clk_i);
        nrst_i = 1'h1;
        repeat (6) @(negedge sys_clk_i);
        chk({full_duplex_o, autoneg_en_o, link_100_o}, {1'h0, sp, sp});
        chk({data_hi_pd_en_o, bus32_o}, {{16{!w}}, w});
        {speed_strap_i, eeprom_data_io_i} = {!sp, !w};
        repeat (3) @(negedge sys_clk_i);
        chk({link_100_o, bus32_o}, {sp, w});
    endtask : rst
    task xs(input logic w, c, input logic [6:0] a, input logic f,
        input logic [31:0] d, input logic p, input logic [1:0] t,
        input logic [6:0] ea);
        mdl.acc(w, c, a, f, d);
        chk(w ? core_wr_o : core_rd_o, p);
        chk(wake_o, low_power_i && c && w);
        if (p)
            chk({core_target_o, core_addr_o}, {t, ea});
        if (p && !w)
            chk(data_oe_o, msk);
        mdl.rel;
    endtask : xs
    // ========================================
    // sequence
    initial
    begin
        {big_endian_i, low_power_i, irq_pol_high_i, irq_open_drain_i} = 4'h0;
        {crossover_auto_enable_i, reversal_detected_i, manual_reverse_i} = 3'h0;
        {general_output_three_i, mii_tx_en_i, mii_tx_clk_i} = 3'h0;
        {ee_select_i, ee_dout_i, ee_dout_en_i} = 3'h0;
        // only source one active, so both select bits matter
        {irq_sources_i, irq_src_sel_i} = 6'h08;
        pin_mode_i = HPP_PIN_EEPROM;
        core_rdata_i = 32'h1122a3b4;
        for (int k = 0; k < 2; k++)
        begin
            rst(k[0], !k[0]);
            xs(1, 1, 7'h25, 0, 1, 0, 0, 0);
            for (int b = 0; b < 2; b++)
            begin
                big_endian_i = b[0];
                xs(0, 1, 7'h25, 0, 0, 1, HPP_TGT_CSR, 7'h25);
                chk(data_o & msk, (b[0] ? (w32 ? 32'hb4a32211 : 32'hb4a3)
                    : 32'h1122a3b4) & msk);
            end
            big_endian_i = 1'h0;
            xs(0, 1, 7'h05, 0, 0, 1, HPP_TGT_RX_FIFO, 7'h05);
            xs(0, 1, 7'h1a, 0, 0, 1, HPP_TGT_TX_FIFO, 7'h1a);
            xs(0, 1, 7'h7f, 0, 0, 1, HPP_TGT_CSR, 7'h7f);
            xs(0, 1, 7'h7e, 1, 0, 1, HPP_TGT_RX_FIFO, 7'h02);
            xs(1, 1, 7'h7d, 1, 32'hcafe5a5a, 1, HPP_TGT_TX_FIFO, 7'h01);
            chk(core_wdata_o, 32'hcafe5a5a & msk);
            big_endian_i = 1'h1;
            xs(1, 1, 7'h7d, 1, 32'h12345678, 1, HPP_TGT_TX_FIFO, 7'h01);
            chk(core_wdata_o, w32 ? 32'h78563412 : 32'h00007856);
            big_endian_i = 1'h0;
            xs(0, 0, 7'h25, 0, 0, 0, 0, 0);
            xs(1, 0, 7'h25, 0, 1, 0, 0, 0);
            low_power_i = 1'h1;
            xs(1, 1, 7'h25, 0, 1, 0, 0, 0);
            low_power_i = 1'h0;
            xs(1, 1, 7'h25, 0, 1, 0, 0, 0);
        end
        for (int i = 0; i < 16; i++)
        begin
            {irq_open_drain_i, irq_pol_high_i, irq_src_sel_i} = i[3:0];
            repeat (2) @(negedge sys_clk_i);
            ex = (i[1:0] == 2'h1);
            chk({irq_oe_o, irq_o}, i[3] ? {ex, 1'h0} : {1'h1, ex == i[2]});
        end
        for (int i = 0; i < 8; i++)
        begin
            {crossover_auto_enable_i, reversal_detected_i, manual_reverse_i} = i[2:0];
            repeat (2) @(negedge sys_clk_i);
            chk({crossover_auto_o, swap_pairs_o}, {i[2], i[0] | i[2] & i[1]});
        end
        ee_select_i = 1'h1;
        for (int i = 0; i < 16; i++)
        begin
            pin_mode_i = hpp_pin_mode_t'(i[1:0]);
            {general_output_three_i, mii_tx_clk_i} = {i[2], i[3]};
            {ee_dout_en_i, ee_dout_i, mii_tx_en_i} = {i[2], i[3], !i[2]};
            eeprom_data_io_i = !i[3];
            ov = {i[3], !i[2], i[2], i[3]};
            @(negedge sys_clk_i);
            chk(eeprom_data_io_oe_o, i[1:0] != 0 || i[2]);
            if (i[1:0] != 0 || i[2])
                chk(eeprom_data_io_o, ov[i[1:0]]);
            chk({eeprom_select_o, ee_din_o}, {i[1:0] == 0, i[1:0] == 0 && !i[3]});
        end
        close_out;
    end
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            close_out;
        end
    end
endmodule : hpp_host_port_tb_top
`default_nettype wire
